// ### hw/pcscs_top.sv
// primary clock select, bus clock outputs and their control registers
// Operation
// - host mode with clock drive set takes the board reference as primary
// - agent mode takes the bus clock input as primary clock
// - host drive mode feeds reference to halving stage and output muxes
// - halve select picks reference or reference/2 for the sync output
// - each bus clock output runs only when its own enable bit is set
// - internal clocking locks to the sync clock returning on sync input
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
module pcscs_top #(
	parameter int NUM_OUT = 5
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// reset-time configuration
	input wire logic HOST_MODE_SEL_I,
	input wire logic BUS_CLOCK_DRIVE_SEL_I,
	input wire logic SYNC_OUT_HALVE_SEL_I,
	// clock pins
	input wire logic BOARD_REF_CLOCK_IN_I,
	input wire logic BUS_CLOCK_IN_I,
	input wire logic SYNC_IN_I,
	output logic SYNC_OUT_O,
	output logic [NUM_OUT-1:0] BUS_CLOCK_OUT_O,
	output logic PRIMARY_CLOCK_O,
	output logic PRIMARY_IS_REF_O,
	output logic SYNC_LOCKED_O,
	// axi4-lite slave
	input wire logic [3:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [3:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I
);
	// ---------------------------------------------------------------
	// reset release and configuration capture
	// ---------------------------------------------------------------
	logic rst_meta, rst_n;
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	pcscs_pkg::pcscs_cfg_t cfg, next_cfg;
	logic cfg_done, next_cfg_done;
	logic host_drive;
	logic next_is_ref;
	always_comb begin
		next_cfg = cfg;
		next_cfg_done = 1'b1;
		if (!cfg_done) begin
			next_cfg.host_mode_sel = HOST_MODE_SEL_I;
			next_cfg.bus_clock_drive_sel = BUS_CLOCK_DRIVE_SEL_I;
			next_cfg.sync_out_halve_sel = SYNC_OUT_HALVE_SEL_I;
		end
		next_is_ref = next_cfg.host_mode_sel & next_cfg.bus_clock_drive_sel;
	end
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= '0;
			cfg_done <= 1'b0;
			PRIMARY_IS_REF_O <= 1'b0;
		end else begin
			cfg <= next_cfg;
			cfg_done <= next_cfg_done;
			PRIMARY_IS_REF_O <= next_is_ref;
		end
	end
	assign host_drive = cfg.host_mode_sel & cfg.bus_clock_drive_sel;

	// ---------------------------------------------------------------
	// clock generation
	// ---------------------------------------------------------------
	logic ref_q, ref_prev, half, next_half, src;
	logic bus_q, sync_q, sync_prev;
	logic [2:0] lock_cnt, next_lock_cnt;
	logic [NUM_OUT-1:0] en_eff, next_en_eff;
	logic [31:0] out_ctrl, next_out_ctrl;
	logic next_sync_out, next_primary, next_locked;
	logic [NUM_OUT-1:0] next_bus_out;

	assign src = cfg.sync_out_halve_sel ? half : ref_q;
	always_comb begin
		next_half = half;
		if (host_drive && ref_q && !ref_prev)
			next_half = ~half;
		next_sync_out = host_drive & src;
		next_primary = host_drive ? ref_q : bus_q;
		next_en_eff = en_eff;
		// enables move only while the source is low
		if (!src)
			next_en_eff = out_ctrl[NUM_OUT-1:0];
		next_bus_out = {NUM_OUT{host_drive & src}} & en_eff;
		next_lock_cnt = lock_cnt;
		if (!host_drive)
			next_lock_cnt = '0;
		else if (sync_q && !sync_prev && lock_cnt != pcscs_pkg::LOCK_EDGES)
			next_lock_cnt = lock_cnt + 3'h1;
		next_locked = (next_lock_cnt == pcscs_pkg::LOCK_EDGES);
	end
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ref_q <= 1'b0;
			ref_prev <= 1'b0;
			half <= 1'b0;
			bus_q <= 1'b0;
			sync_q <= 1'b0;
			sync_prev <= 1'b0;
			lock_cnt <= '0;
			en_eff <= '0;
			SYNC_OUT_O <= 1'b0;
			BUS_CLOCK_OUT_O <= '0;
			PRIMARY_CLOCK_O <= 1'b0;
			SYNC_LOCKED_O <= 1'b0;
		end else begin
			ref_q <= BOARD_REF_CLOCK_IN_I;
			ref_prev <= ref_q;
			half <= next_half;
			bus_q <= BUS_CLOCK_IN_I;
			sync_q <= SYNC_IN_I;
			sync_prev <= sync_q;
			lock_cnt <= next_lock_cnt;
			en_eff <= next_en_eff;
			SYNC_OUT_O <= next_sync_out;
			BUS_CLOCK_OUT_O <= next_bus_out;
			PRIMARY_CLOCK_O <= next_primary;
			SYNC_LOCKED_O <= next_locked;
		end
	end

	// ---------------------------------------------------------------
	// register slave
	// ---------------------------------------------------------------
	logic wr_go, rd_go;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, status;
	assign wr_go = AWVALID_I & WVALID_I & ~BVALID_O;
	assign rd_go = ARVALID_I & ~RVALID_O;
	assign AWREADY_O = wr_go;
	assign WREADY_O = wr_go;
	assign ARREADY_O = ~RVALID_O;
	always_comb begin
		status = '0;
		status[pcscs_pkg::ST_HOST] = cfg.host_mode_sel;
		status[pcscs_pkg::ST_DRIVE] = cfg.bus_clock_drive_sel;
		status[pcscs_pkg::ST_HALVE] = cfg.sync_out_halve_sel;
		status[pcscs_pkg::ST_PRI_REF] = host_drive;
		status[pcscs_pkg::ST_LOCK] = SYNC_LOCKED_O;
		next_out_ctrl = out_ctrl;
		next_bvalid = BVALID_O & ~BREADY_I;
		next_bresp = BRESP_O;
		if (wr_go) begin
			next_bvalid = 1'b1;
			next_bresp = pcscs_pkg::RESP_OKAY;
			if (AWADDR_I == pcscs_pkg::OFS_OUT_CTRL) begin
				for (int b = 0; b < 4; b++)
					if (WSTRB_I[b])
						next_out_ctrl[b*8 +: 8] = WDATA_I[b*8 +: 8];
				next_out_ctrl[31:NUM_OUT] = '0;
			end else if (AWADDR_I != pcscs_pkg::OFS_STATUS)
				next_bresp = pcscs_pkg::RESP_SLVERR;
		end
		next_rvalid = RVALID_O & ~RREADY_I;
		next_rdata = RDATA_O;
		next_rresp = RRESP_O;
		if (rd_go) begin
			next_rvalid = 1'b1;
			next_rresp = pcscs_pkg::RESP_OKAY;
			if (ARADDR_I == pcscs_pkg::OFS_OUT_CTRL)
				next_rdata = out_ctrl;
			else if (ARADDR_I == pcscs_pkg::OFS_STATUS)
				next_rdata = status;
			else begin
				next_rdata = '0;
				next_rresp = pcscs_pkg::RESP_SLVERR;
			end
		end
	end
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			out_ctrl <= pcscs_pkg::OUT_CTRL_RST;
			BVALID_O <= 1'b0;
			BRESP_O <= 2'h0;
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h0000_0000;
			RRESP_O <= 2'h0;
		end else begin
			out_ctrl <= next_out_ctrl;
			BVALID_O <= next_bvalid;
			BRESP_O <= next_bresp;
			RVALID_O <= next_rvalid;
			RDATA_O <= next_rdata;
			RRESP_O <= next_rresp;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!rst_n);

	a_primary_ref: assert property (host_drive |=> PRIMARY_CLOCK_O == $past(ref_q)) else $error("primary not reference");
	a_primary_bus: assert property (!host_drive && cfg_done |=> PRIMARY_CLOCK_O == $past(bus_q)) else $error("primary not bus clock");
	a_half_toggle: assert property (host_drive && ref_q && !ref_prev |=> half != $past(half)) else $error("halver missed edge");
	a_sync_src: assert property (cfg_done |=> SYNC_OUT_O == $past(host_drive & src)) else $error("sync output wrong source");
	a_out_enable: assert property (!en_eff[0] |=> !BUS_CLOCK_OUT_O[0]) else $error("disabled output moved");
	a_idle_low: assert property (!out_ctrl[0] && !src |=> ##1 !BUS_CLOCK_OUT_O[0]) else $error("disabled output not low");
	a_no_runt: assert property (src && $stable(src) |=> $stable(en_eff)) else $error("enable moved while high");
	a_lock_count: assert property (!host_drive |=> !SYNC_LOCKED_O) else $error("locked outside drive mode");
	a_write_resp: assert property (wr_go |=> BVALID_O) else $error("write not answered");

	c_drive_mode: cover property (host_drive ##1 SYNC_OUT_O);
	c_locked: cover property ($rose(SYNC_LOCKED_O));
	c_out_run: cover property (BUS_CLOCK_OUT_O[0] ##1 !BUS_CLOCK_OUT_O[0]);
	c_bad_addr: cover property (RVALID_O && RRESP_O == pcscs_pkg::RESP_SLVERR);
endmodule : pcscs_top

// ### hw/pcscs_pkg.sv
// shared constants and types of the bus clock source selector
package pcscs_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_OUT_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [31:0] OUT_CTRL_RST = 32'h0000_0000;
	// status bit positions
	localparam int ST_HOST = 0;
	localparam int ST_DRIVE = 1;
	localparam int ST_HALVE = 2;
	localparam int ST_PRI_REF = 3;
	localparam int ST_LOCK = 4;
	// ---------------------------------------------------------------
	// responses and counts
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] LOCK_EDGES = 3'h4;
	// reset-time configuration captured after reset release
	typedef struct packed {
		logic host_mode_sel;
		logic bus_clock_drive_sel;
		logic sync_out_halve_sel;
	} pcscs_cfg_t;
endpackage : pcscs_pkg

// ### dv/pcscs_far_model.sv
// far side: board oscillator, bus clock of the agents, sync loop trace
module pcscs_far_model (
	// bench clock
	input wire logic clk_i,
	// sync loop
	input wire logic sync_out_i,
	output logic sync_in_o,
	// free running sources
	output logic ref_o = 1'b0,
	output logic bus_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] n = 3'h0;
	// reference period 8 cycles, bus clock period 4 cycles
	always @(posedge clk_i) begin
		n <= n + 3'h1;
		bus_o <= n[1];
		ref_o <= n[2];
	end
	// board trace returns the sync output to the sync input
	assign sync_in_o = sync_out_i;
endmodule : pcscs_far_model

// ### dv/pci_clock_source_select_tb.sv
// self-checking bench of the bus clock source selector
module pci_clock_source_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_I = 0, RST_N_I = 0;
	logic HOST_MODE_SEL_I = 1, BUS_CLOCK_DRIVE_SEL_I = 1;
	logic SYNC_OUT_HALVE_SEL_I = 0;
	logic BOARD_REF_CLOCK_IN_I, BUS_CLOCK_IN_I, SYNC_IN_I, SYNC_OUT_O;
	logic PRIMARY_CLOCK_O, PRIMARY_IS_REF_O, SYNC_LOCKED_O;
	logic [4:0] BUS_CLOCK_OUT_O;
	logic [3:0] AWADDR_I = 0, ARADDR_I = 0, WSTRB_I = 0;
	logic [31:0] WDATA_I = 0, RDATA_O;
	logic AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0;
	logic ARVALID_I = 0, RREADY_I = 0;
	logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
	logic [1:0] BRESP_O, RRESP_O;
	int errors = 0, checks = 0;
	always #2 CLK_I = ~CLK_I;
	pcscs_top dut (
		.CLK_I(CLK_I),
		.RST_N_I(RST_N_I),
		.HOST_MODE_SEL_I(HOST_MODE_SEL_I),
		.BUS_CLOCK_DRIVE_SEL_I(BUS_CLOCK_DRIVE_SEL_I),
		.SYNC_OUT_HALVE_SEL_I(SYNC_OUT_HALVE_SEL_I),
		.BOARD_REF_CLOCK_IN_I(BOARD_REF_CLOCK_IN_I),
		.BUS_CLOCK_IN_I(BUS_CLOCK_IN_I),
		.SYNC_IN_I(SYNC_IN_I),
		.SYNC_OUT_O(SYNC_OUT_O),
		.BUS_CLOCK_OUT_O(BUS_CLOCK_OUT_O),
		.PRIMARY_CLOCK_O(PRIMARY_CLOCK_O),
		.PRIMARY_IS_REF_O(PRIMARY_IS_REF_O),
		.SYNC_LOCKED_O(SYNC_LOCKED_O),
		.AWADDR_I(AWADDR_I),
		.AWVALID_I(AWVALID_I),
		.AWREADY_O(AWREADY_O),
		.WDATA_I(WDATA_I),
		.WSTRB_I(WSTRB_I),
		.WVALID_I(WVALID_I),
		.WREADY_O(WREADY_O),
		.BRESP_O(BRESP_O),
		.BVALID_O(BVALID_O),
		.BREADY_I(BREADY_I),
		.ARADDR_I(ARADDR_I),
		.ARVALID_I(ARVALID_I),
		.ARREADY_O(ARREADY_O),
		.RDATA_O(RDATA_O),
		.RRESP_O(RRESP_O),
		.RVALID_O(RVALID_O),
		.RREADY_I(RREADY_I)
	);
	pcscs_far_model far (.clk_i(CLK_I), .sync_out_i(SYNC_OUT_O),
		.sync_in_o(SYNC_IN_I), .ref_o(BOARD_REF_CLOCK_IN_I),
		.bus_o(BUS_CLOCK_IN_I));
	task chk(input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge CLK_I);
		AWADDR_I <= a;
		WDATA_I <= d;
		WSTRB_I <= 4'hF;
		AWVALID_I <= 1'b1;
		WVALID_I <= 1'b1;
		BREADY_I <= 1'b1;
		do @(posedge CLK_I); while (AWREADY_O !== 1'b1 || WREADY_O !== 1'b1);
		AWVALID_I <= 1'b0;
		WVALID_I <= 1'b0;
		do @(posedge CLK_I); while (BVALID_O !== 1'b1);
		BREADY_I <= 1'b0;
		chk(BRESP_O, r);
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge CLK_I);
		ARADDR_I <= a;
		ARVALID_I <= 1'b1;
		RREADY_I <= 1'b1;
		do @(posedge CLK_I); while (ARREADY_O !== 1'b1);
		ARVALID_I <= 1'b0;
		do @(posedge CLK_I); while (RVALID_O !== 1'b1);
		RREADY_I <= 1'b0;
		chk(RDATA_O, d);
		chk(RRESP_O, r);
	endtask : rd
	// rising edges over 64 cycles; z gathers activity of disabled outputs
	task meas(output logic [31:0] s, p, b, z);
		logic ls, lp, lb;
		{s, p, b, z} = '0;
		{ls, lp, lb} = {SYNC_OUT_O, PRIMARY_CLOCK_O, BUS_CLOCK_OUT_O[0]};
		repeat (64) begin
			@(posedge CLK_I);
			s += SYNC_OUT_O & ~ls;
			p += PRIMARY_CLOCK_O & ~lp;
			b += BUS_CLOCK_OUT_O[0] & ~lb;
			z |= BUS_CLOCK_OUT_O & 5'h0A;
			{ls, lp, lb} = {SYNC_OUT_O, PRIMARY_CLOCK_O, BUS_CLOCK_OUT_O[0]};
		end
	endtask : meas
	task mode(input logic [2:0] m, input logic [31:0] st, ns, np, nb);
		logic [31:0] s, p, b, z;
		@(posedge CLK_I);
		RST_N_I <= 1'b0;
		{HOST_MODE_SEL_I, BUS_CLOCK_DRIVE_SEL_I, SYNC_OUT_HALVE_SEL_I} <= m;
		repeat (4) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		repeat (60) @(posedge CLK_I);
		rd(4'h0, 32'h0, 2'h0);
		wr(4'h0, 32'hFFFF_FFFF, 2'h0);
		rd(4'h0, 32'h1F, 2'h0);
		wr(4'h0, 32'h15, 2'h0);
		wr(4'h4, 32'h0, 2'h0);
		repeat (20) @(posedge CLK_I);
		rd(4'h4, st, 2'h0);
		chk(PRIMARY_IS_REF_O, st[3]);
		chk(SYNC_LOCKED_O, st[4]);
		meas(s, p, b, z);
		chk(s, ns);
		chk(p, np);
		chk(b, nb);
		chk(z, 32'h0);
	endtask : mode
	task give_verdict;
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	// -------------------------------------------------------------------
	// strap sets: host+drive, host+drive+halve, host only, agent
	// -------------------------------------------------------------------
	initial begin
		mode(3'b110, 32'h1B, 8, 8, 8);
		mode(3'b111, 32'h1F, 4, 8, 4);
		mode(3'b100, 32'h01, 0, 16, 0);
		mode(3'b000, 32'h00, 0, 16, 0);
		rd(4'h8, 32'h0, pcscs_pkg::RESP_SLVERR);
		wr(4'h8, 32'h1F, pcscs_pkg::RESP_SLVERR);
		rd(4'h0, 32'h15, 2'h0);
		give_verdict();
	end
	initial begin
		#20000;
		errors++;
		give_verdict();
	end
endmodule : pci_clock_source_select_tb
